// [logic/spiee_pkg.sv]
// Shared constants for the serial EEPROM link and its controller
package spiee_pkg;
	localparam int ADDR_W = 11;
	localparam int PAGE_MAX = 32;
	localparam int PAGE_SMALL = 16;
	localparam int CLK_KHZ = 40000;
	localparam int T_WRITE_MS = 5;
	// Longest write time in clock cycles, exact: 5 ms at 40000 kHz is 200000
	localparam int WRITE_CYC = T_WRITE_MS * CLK_KHZ;
	localparam int TIMER_W = 18;
	localparam int HALF_SCK = 8;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
	localparam logic [7:0] LATCH_SET_CMD = 8'h06;
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
	localparam int ST_BUSY = 0;
	localparam int ST_LATCH = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_PROT_EN = 7;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_ALL = 2'h3;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ADDR = 5'h04;
	localparam logic [4:0] REG_WDATA = 5'h08;
	localparam logic [4:0] REG_RDATA = 5'h0c;
	localparam logic [4:0] REG_STAT = 5'h10;
	localparam int CT_OP = 0;
	localparam int CT_HAS_ADDR = 8;
	localparam int CT_NBYTES = 12;
	localparam int CT_START = 16;
	localparam int CT_HOLD = 17;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [5:0] OP_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS = 6'h10;
endpackage

// [logic/spiee_if.sv]
// Serial link between the EEPROM end and the controller end
interface spiee_if;
	logic cs_b;
	logic sck;
	logic si;
	logic hold_b;
	logic so;
	logic so_oe;
	logic so_line;
	// Undriven output line is pulled high
	assign so_line = so_oe ? so : 1'b1;
	modport dev (input cs_b, sck, si, hold_b, output so, so_oe);
	modport host (output cs_b, sck, si, hold_b, input so_line);
endinterface

// [logic/spiee_sync.sv]
// Two-stage synchroniser for signals arriving from the link
module spiee_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] q1;
		logic [W-1:0] q2;
	} spiee_sync_t;
	spiee_sync_t r, n;
	always_comb begin
		n.q1 = i_d;
		n.q2 = r.q1;
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= {RST_VAL, RST_VAL};
		end else begin
			r <= n;
		end
	end
	assign o_q = r.q2;
endmodule

// [logic/spiee_dev.sv]
// EEPROM end: command sequencer, array, page buffer and write timer
module spiee_dev #(
	parameter int PAGE_BYTES = spiee_pkg::PAGE_SMALL,
	parameter int WRITE_CYC = spiee_pkg::WRITE_CYC
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_B,
	// Link
	spiee_if.dev LINK,
	// Status
	output logic O_BUSY,
	output logic O_LATCH
);
	typedef enum logic [3:0] {
		PH_CMD = 4'h0,
		PH_ADDH = 4'h1,
		PH_ADDL = 4'h2,
		PH_RDATA = 4'h3,
		PH_WDATA = 4'h4,
		PH_SRD = 4'h5,
		PH_SWR = 4'h6,
		PH_SWDONE = 4'h7,
		PH_LATCH = 4'h8,
		PH_IGN = 4'h9
	} spiee_ph_t;
	typedef struct packed {
		spiee_ph_t ph;
		logic [7:0] cmd;
		logic [7:0] sr;
		logic [2:0] bcnt;
		logic [2:0] ocnt;
		logic [spiee_pkg::ADDR_W-1:0] addr;
		logic [7:0] out_sr;
		logic ostart;
		logic so;
		logic so_oe;
		logic write_latch_flag;
		logic busy;
		logic [spiee_pkg::TIMER_W-1:0] timer;
		logic [1:0] bp;
		logic pin_protect_enable;
		logic [1:0] new_bp;
		logic new_pin_protect_enable;
		logic stat_pend;
		logic commit;
		logic [spiee_pkg::PAGE_MAX-1:0][7:0] pbuf;
		logic [spiee_pkg::PAGE_MAX-1:0] pvalid;
		logic [4:0] woff;
		logic sck_q;
		logic cs_q;
	} spiee_dev_t;
	localparam logic [4:0] OFF_MASK = 5'(PAGE_BYTES - 1);
	localparam logic [spiee_pkg::TIMER_W-1:0] WR_LOAD =
		spiee_pkg::TIMER_W'(WRITE_CYC - 1);
	spiee_dev_t r, n;
	logic [3:0] sy;
	logic [7:0] mem [0:(1 << spiee_pkg::ADDR_W) - 1];
	logic [7:0] status;
	logic [7:0] byte_in;
	logic rise;
	logic fall;
	spiee_sync #(.W(4), .RST_VAL(4'h9)) u_sync (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_d({LINK.hold_b, LINK.si, LINK.sck, LINK.cs_b}),
		.o_q(sy)
	);
	function automatic logic prot(input logic [1:0] bp,
		input logic [spiee_pkg::ADDR_W-1:0] a);
		prot = (bp == spiee_pkg::BP_ALL) ||
			(bp == spiee_pkg::BP_HALF && a[10]) ||
			(bp == spiee_pkg::BP_QUARTER && (&a[10:9]));
	endfunction
	always_comb begin
		status = 8'h00;
		status[spiee_pkg::ST_BUSY] = r.busy;
		status[spiee_pkg::ST_LATCH] = r.write_latch_flag;
		status[spiee_pkg::ST_BP_LO] = r.bp[0];
		status[spiee_pkg::ST_BP_HI] = r.bp[1];
		status[spiee_pkg::ST_PROT_EN] = r.pin_protect_enable;
		n = r;
		n.commit = 1'b0;
		n.sck_q = sy[1];
		n.cs_q = sy[0];
		rise = sy[1] & ~r.sck_q;
		fall = ~sy[1] & r.sck_q;
		byte_in = {r.sr[6:0], sy[2]};
		if (r.busy) begin
			if (r.timer == '0) begin
				n.busy = 1'b0;
				n.write_latch_flag = 1'b0;
				n.commit = 1'b1;
				if (r.stat_pend) begin
					n.bp = r.new_bp;
					n.pin_protect_enable = r.new_pin_protect_enable;
				end
			end else begin
				n.timer = r.timer - 1'b1;
			end
		end
		if (sy[0]) begin
			if (!r.cs_q) begin
				// Only a select rise with no stray bits counts
				if (r.ph == PH_LATCH && r.bcnt == 3'h0) begin
					n.write_latch_flag = (r.cmd == spiee_pkg::LATCH_SET_CMD);
				end
				if (!r.busy && r.bcnt == 3'h0 &&
					((r.ph == PH_WDATA && |r.pvalid) ||
					r.ph == PH_SWDONE)) begin
					n.busy = 1'b1;
					n.timer = WR_LOAD;
					n.stat_pend = (r.ph == PH_SWDONE);
				end
			end
			n.ph = PH_CMD;
			n.bcnt = 3'h0;
			n.so_oe = 1'b0;
		end else if (!sy[3]) begin
			// Paused: nothing moves, output released
			n.so_oe = 1'b0;
		end else begin
			if (rise) begin
				n.sr = byte_in;
				n.bcnt = r.bcnt + 1'b1;
				if (r.bcnt == 3'h7) begin
					case (r.ph)
						PH_CMD: begin
							n.cmd = byte_in;
							n.ph = PH_IGN;
							case (byte_in)
								spiee_pkg::OP_READ: begin
									n.ph = r.busy ? PH_IGN : PH_ADDH;
								end
								spiee_pkg::OP_WRITE: begin
									n.pvalid = '0;
									n.ph = (r.write_latch_flag && !r.busy) ? PH_ADDH :
										PH_IGN;
								end
								spiee_pkg::LATCH_SET_CMD,
								spiee_pkg::LATCH_CLEAR_CMD: begin
									n.ph = PH_LATCH;
								end
								spiee_pkg::STATUS_READ_CMD: begin
									n.ph = PH_SRD;
									n.out_sr = status;
									n.ocnt = 3'h0;
									n.ostart = 1'b0;
								end
								spiee_pkg::STATUS_WRITE_CMD: begin
									n.ph = (r.write_latch_flag && !r.busy) ? PH_SWR :
										PH_IGN;
								end
								default: begin
									n.ph = PH_IGN;
								end
							endcase
						end
						PH_ADDH: begin
							// Upper five address bits are dropped
							n.addr[10:8] = byte_in[2:0];
							n.ph = PH_ADDL;
						end
						PH_ADDL: begin
							n.addr[7:0] = byte_in;
							n.ocnt = 3'h0;
							n.ostart = 1'b0;
							if (r.cmd == spiee_pkg::OP_READ) begin
								n.ph = PH_RDATA;
								n.out_sr = mem[{r.addr[10:8], byte_in}];
							end else begin
								n.ph = PH_WDATA;
								n.woff = byte_in[4:0] & OFF_MASK;
							end
						end
						PH_WDATA: begin
							n.pbuf[r.woff] = byte_in;
							n.pvalid[r.woff] = 1'b1;
							n.woff = (r.woff + 1'b1) & OFF_MASK;
						end
						PH_SWR: begin
							n.new_bp = byte_in[spiee_pkg::ST_BP_HI:
								spiee_pkg::ST_BP_LO];
							n.new_pin_protect_enable = byte_in[spiee_pkg::ST_PROT_EN];
							n.ph = PH_SWDONE;
						end
						PH_SWDONE, PH_LATCH: begin
							n.ph = PH_IGN;
						end
						default: begin
							n.ph = r.ph;
						end
					endcase
				end else if (r.ph == PH_SWDONE || r.ph == PH_LATCH) begin
					n.ph = PH_IGN;
				end
			end
			if (fall && (r.ph == PH_RDATA || r.ph == PH_SRD)) begin
				n.so = r.out_sr[7];
				n.out_sr = {r.out_sr[6:0], 1'b0};
				n.ocnt = r.ocnt + 1'b1;
				n.ostart = 1'b1;
				if (r.ocnt == 3'h7) begin
					if (r.ph == PH_RDATA) begin
						n.addr = r.addr + 1'b1;
						n.out_sr = mem[r.addr + 1'b1];
					end else begin
						n.out_sr = status;
					end
				end
			end
			n.so_oe = (n.ph == PH_RDATA || n.ph == PH_SRD) &&
				n.ostart;
		end
	end
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			r <= '0;
			r.sck_q <= 1'b0;
			r.cs_q <= 1'b1;
		end else begin
			r <= n;
		end
	end
	// Page commit: only bytes loaded in this frame, within one page
	always_ff @(posedge I_CLK) begin
		if (r.commit && !r.stat_pend) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (r.pvalid[i] && !prot(r.bp, (r.addr & ~11'(OFF_MASK)) |
					11'(i))) begin
					mem[(r.addr & ~11'(OFF_MASK)) | 11'(i)] <= r.pbuf[i];
				end
			end
		end
	end
	assign LINK.so = r.so;
	assign LINK.so_oe = r.so_oe;
	assign O_BUSY = r.busy;
	assign O_LATCH = r.write_latch_flag;
endmodule

// [logic/spiee_host.sv]
// Controller end: AXI4-Lite registers driving one serial frame at a time
module spiee_host (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_B,
	// Link
	spiee_if.host LINK,
	// AXI4-Lite write
	input wire logic [4:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	// AXI4-Lite read
	input wire logic [4:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY
);
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_RUN = 2'h1,
		H_END = 2'h2,
		H_GAP = 2'h3
	} spiee_hst_t;
	typedef struct packed {
		spiee_hst_t st;
		logic [3:0] div;
		logic sck;
		logic cs_b;
		logic si;
		logic [55:0] tx;
		logic [5:0] left;
		logic [31:0] rx;
		logic [7:0] op;
		logic has_addr;
		logic [2:0] nbytes;
		logic hold;
		logic [15:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic aw_got;
		logic w_got;
		logic [4:0] awaddr;
		logic [31:0] wd;
		logic [3:0] ws;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rd;
		logic [1:0] rresp;
	} spiee_host_t;
	localparam logic [3:0] HALF_END = 4'(spiee_pkg::HALF_SCK - 1);
	spiee_host_t r, n;
	logic so_s;
	logic tick;
	spiee_sync #(.W(1), .RST_VAL(1'b1)) u_sync (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_d(LINK.so_line),
		.o_q(so_s)
	);
	always_comb begin
		n = r;
		tick = (r.div == HALF_END);
		// Pause stops the divider so the frame resumes where it stood
		if (!r.hold && r.st != H_IDLE) begin
			n.div = tick ? 4'h0 : r.div + 1'b1;
		end
		case (r.st)
			H_RUN: begin
				if (tick && !r.hold) begin
					n.sck = ~r.sck;
					if (!r.sck) begin
						n.rx = {r.rx[30:0], so_s};
						n.left = r.left - 1'b1;
					end else if (r.left == 6'h0) begin
						n.st = H_END;
					end else begin
						n.tx = {r.tx[54:0], 1'b0};
						n.si = r.tx[54];
					end
				end
			end
			H_END: begin
				if (tick && !r.hold) begin
					n.cs_b = 1'b1;
					n.st = H_GAP;
				end
			end
			H_GAP: begin
				if (tick && !r.hold) begin
					n.st = H_IDLE;
					n.rdata = r.rx;
				end
			end
			default: begin
				n.div = 4'h0;
			end
		endcase
		if (I_AWVALID && r.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = I_AWADDR;
		end
		if (I_WVALID && r.wready) begin
			n.w_got = 1'b1;
			n.wd = I_WDATA;
			n.ws = I_WSTRB;
		end
		if (r.bvalid && I_BREADY) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = spiee_pkg::RESP_OK;
			if (r.awaddr == spiee_pkg::REG_CTRL) begin
				n.op = r.wd[spiee_pkg::CT_OP +: 8];
				n.has_addr = r.wd[spiee_pkg::CT_HAS_ADDR];
				n.nbytes = r.wd[spiee_pkg::CT_NBYTES +: 3];
				n.hold = r.wd[spiee_pkg::CT_HOLD];
				if (r.wd[spiee_pkg::CT_START] && r.st == H_IDLE) begin
					n.op = r.wd[spiee_pkg::CT_OP +: 8];
					n.tx = r.wd[spiee_pkg::CT_HAS_ADDR] ?
						{n.op, r.addr, r.wdata} :
						{n.op, r.wdata, 16'h0000};
					n.si = n.op[7];
					n.cs_b = 1'b0;
					n.st = H_RUN;
					n.div = 4'h0;
					// Frame length: opcode, optional address, data bytes
					n.left = spiee_pkg::OP_BITS +
						(n.has_addr ? spiee_pkg::ADDR_BITS : 6'h0) +
						{n.nbytes, 3'h0};
				end
			end else if (r.awaddr == spiee_pkg::REG_ADDR) begin
				for (int i = 0; i < 2; i++) begin
					if (r.ws[i]) begin
						n.addr[8*i +: 8] = r.wd[8*i +: 8];
					end
				end
			end else if (r.awaddr == spiee_pkg::REG_WDATA) begin
				for (int i = 0; i < 4; i++) begin
					if (r.ws[i]) begin
						n.wdata[8*i +: 8] = r.wd[8*i +: 8];
					end
				end
			end else begin
				n.bresp = spiee_pkg::RESP_SLVERR;
			end
		end
		if (r.rvalid && I_RREADY) begin
			n.rvalid = 1'b0;
		end
		if (I_ARVALID && r.arready) begin
			n.rvalid = 1'b1;
			n.rresp = spiee_pkg::RESP_OK;
			n.rd = 32'h0;
			if (I_ARADDR == spiee_pkg::REG_CTRL) begin
				n.rd[spiee_pkg::CT_OP +: 8] = r.op;
				n.rd[spiee_pkg::CT_HAS_ADDR] = r.has_addr;
				n.rd[spiee_pkg::CT_NBYTES +: 3] = r.nbytes;
				n.rd[spiee_pkg::CT_HOLD] = r.hold;
			end else if (I_ARADDR == spiee_pkg::REG_ADDR) begin
				n.rd[15:0] = r.addr;
			end else if (I_ARADDR == spiee_pkg::REG_WDATA) begin
				n.rd = r.wdata;
			end else if (I_ARADDR == spiee_pkg::REG_RDATA) begin
				n.rd = r.rdata;
			end else if (I_ARADDR == spiee_pkg::REG_STAT) begin
				n.rd[0] = (r.st != H_IDLE);
			end else begin
				n.rresp = spiee_pkg::RESP_SLVERR;
			end
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;
		n.arready = !n.rvalid;
	end
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			r <= '0;
			r.cs_b <= 1'b1;
		end else begin
			r <= n;
		end
	end
	assign LINK.cs_b = r.cs_b;
	assign LINK.sck = r.sck;
	assign LINK.si = r.si;
	assign LINK.hold_b = ~r.hold;
	assign O_AWREADY = r.awready;
	assign O_WREADY = r.wready;
	assign O_BVALID = r.bvalid;
	assign O_BRESP = r.bresp;
	assign O_ARREADY = r.arready;
	assign O_RVALID = r.rvalid;
	assign O_RDATA = r.rd;
	assign O_RRESP = r.rresp;
endmodule

// [dv/spiee_monitor.sv]
// Checker of the serial link between the two ends
module spiee_monitor #(
	parameter int WRITE_CYC = 50
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Link
	input wire logic i_cs_b,
	input wire logic i_sck,
	input wire logic i_si,
	input wire logic i_hold_b,
	input wire logic i_so,
	input wire logic i_so_oe,
	// Status
	input wire logic i_busy,
	input wire logic i_latch
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [17:0] busy_cnt;
	} spiee_mon_t;
	spiee_mon_t st_r;
	spiee_mon_t st_nxt;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	always_comb begin
		st_nxt = st_r;
		st_nxt.busy_cnt = i_busy ? st_r.busy_cnt + 18'h1 : 18'h0;
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	a_si_steady_rise: assert property ($rose(i_sck) |-> $stable(i_si))
		else $error("si moved at sck rise");
	a_sck_idle_desel: assert property (i_cs_b |-> !i_sck)
		else $error("sck active while deselected");
	// Output may only move while sck is low, after a fall
	a_so_after_fall: assert property (
		i_so_oe && $past(i_so_oe) && $changed(i_so) |-> !i_sck)
		else $error("so changed while sck high");
	a_desel_release: assert property (i_cs_b [*5] |-> !i_so_oe)
		else $error("so driven while deselected");
	a_hold_release: assert property (!i_hold_b [*5] |-> !i_so_oe)
		else $error("so driven during pause");
	a_oe_in_frame: assert property (
		$rose(i_so_oe) |-> !i_cs_b && i_hold_b)
		else $error("so enabled outside a frame");
	a_latch_on_desel: assert property ($rose(i_latch) |-> i_cs_b)
		else $error("latch set while selected");
	a_busy_start: assert property (
		$rose(i_busy) |-> i_cs_b && i_latch)
		else $error("write started without latch or select rise");
	a_busy_clr_latch: assert property (
		$fell(i_busy) |-> ##[0:2] !i_latch)
		else $error("latch not cleared after write");
	a_busy_bounded: assert property (
		st_r.busy_cnt <= WRITE_CYC + 2)
		else $error("internal write too long");
	c_busy: cover property ($rose(i_busy));
	c_latch: cover property ($rose(i_latch));
	c_out: cover property ($rose(i_so_oe));
	c_pause: cover property (!i_hold_b && !i_cs_b);
endmodule

// [dv/tb_spi_eeprom_read_write_sequencer.sv]
// Bench joining the EEPROM end and the controller end
module tb_spi_eeprom_read_write_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	// Long enough to fit a status and a read frame inside one write
	localparam int WCYC = 2000;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] awaddr = 5'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [4:0] araddr = 5'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, busy, latch;
	logic [1:0] bresp, rresp;
	logic [1:0] rresp_seen;
	logic [31:0] rdata;
	int fail_count = 0;
	int num_checks = 0;
	spiee_if spiee_if_inst();
	spiee_dev #(.PAGE_BYTES(spiee_pkg::PAGE_SMALL), .WRITE_CYC(WCYC))
		spiee_dev_inst (.I_CLK(clk), .I_RST_B(rst_b),
		.LINK(spiee_if_inst), .O_BUSY(busy), .O_LATCH(latch));
	spiee_host spiee_host_inst (.I_CLK(clk), .I_RST_B(rst_b),
		.LINK(spiee_if_inst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
		.O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
		.O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
		.I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
		.O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));
	spiee_monitor #(.WRITE_CYC(WCYC)) spiee_monitor_inst (.i_clk(clk),
		.i_rst_b(rst_b), .i_cs_b(spiee_if_inst.cs_b),
		.i_sck(spiee_if_inst.sck), .i_si(spiee_if_inst.si),
		.i_hold_b(spiee_if_inst.hold_b), .i_so(spiee_if_inst.so),
		.i_so_oe(spiee_if_inst.so_oe), .i_busy(busy), .i_latch(latch));
	always #12.5 clk = ~clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw;
		logic w;
		logic ta;
		logic tw;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(negedge clk);
			ta = aw && awready;
			tw = w && wready;
			@(posedge clk);
			awvalid <= aw && !ta;
			wvalid <= w && !tw;
			aw = aw && !ta;
			w = w && !tw;
		end
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = bvalid;
			r = bresp;
			@(posedge clk);
		end while (!ta);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		logic t;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge clk);
			t = arready;
			@(posedge clk);
		end while (!t);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			t = rvalid;
			d = rdata;
			rresp_seen = rresp;
			@(posedge clk);
		end while (!t);
		rready <= 1'b0;
	endtask
	function automatic logic [31:0] ctl(input logic [7:0] op,
		input logic ha, input logic [2:0] n, input logic hd);
		return {14'h0, hd, 2'h0, n, 3'h0, ha, op};
	endfunction
	task automatic idle();
		logic [31:0] s;
		do rd(spiee_pkg::REG_STAT, s); while (s[0] !== 1'b0);
		repeat (16) @(posedge clk);
	endtask
	task automatic frame(input logic [31:0] c, output logic [31:0] d);
		logic [1:0] r;
		wr(spiee_pkg::REG_CTRL, c | 32'h10000, r);
		idle();
		rd(spiee_pkg::REG_RDATA, d);
	endtask
	task automatic set_aw(input logic [15:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(spiee_pkg::REG_ADDR, {16'h0, a}, r);
		wr(spiee_pkg::REG_WDATA, d, r);
	endtask
	task automatic t_latch();
		logic [31:0] d;
		logic [1:0] r;
		chk({31'h0, latch}, 32'h0);
		frame(ctl(spiee_pkg::LATCH_SET_CMD, 1'b0, 3'h0, 1'b0), d);
		chk({31'h0, latch}, 32'h1);
		frame(ctl(spiee_pkg::LATCH_CLEAR_CMD, 1'b0, 3'h0, 1'b0), d);
		chk({31'h0, latch}, 32'h0);
		// Write opcode rides on behind the latch opcode, no select rise
		set_aw({spiee_pkg::OP_WRITE, 8'h00}, 32'h11223344);
		frame(ctl(spiee_pkg::LATCH_SET_CMD, 1'b1, 3'h1, 1'b0), d);
		chk({30'h0, busy, latch}, 32'h0);
		set_aw(16'h0000, 32'h11223344);
		frame(ctl(spiee_pkg::OP_WRITE, 1'b1, 3'h1, 1'b0), d);
		chk({31'h0, busy}, 32'h0);
		frame(ctl(spiee_pkg::LATCH_SET_CMD, 1'b0, 3'h0, 1'b0), d);
		frame(ctl(spiee_pkg::OP_WRITE, 1'b1, 3'h0, 1'b0), d);
		chk({30'h0, busy, latch}, 32'h1);
		wr(5'h14, 32'h0, r);
		chk({30'h0, r}, {30'h0, spiee_pkg::RESP_SLVERR});
		rd(5'h14, d);
		chk(d, 32'h0);
		chk({30'h0, rresp_seen}, {30'h0, spiee_pkg::RESP_SLVERR});
		$display("test latch done");
	endtask
	task automatic t_page();
		logic [31:0] d;
		// Top four address bits set on purpose, must be ignored
		set_aw(16'hf7fe, 32'ha1b2c3d4);
		frame(ctl(spiee_pkg::OP_WRITE, 1'b1, 3'h4, 1'b0), d);
		chk({31'h0, busy}, 32'h1);
		frame(ctl(spiee_pkg::STATUS_READ_CMD, 1'b0, 3'h1, 1'b0), d);
		chk({30'h0, d[1:0]}, 32'h3);
		set_aw(16'h0000, 32'h0);
		frame(ctl(spiee_pkg::OP_READ, 1'b1, 3'h1, 1'b0), d);
		chk({24'h0, d[7:0]}, 32'hff);
		wait (busy === 1'b0);
		frame(ctl(spiee_pkg::STATUS_READ_CMD, 1'b0, 3'h1, 1'b0), d);
		chk({30'h0, d[1:0]}, 32'h0);
		frame(ctl(spiee_pkg::LATCH_SET_CMD, 1'b0, 3'h0, 1'b0), d);
		set_aw(16'h0000, 32'h5e6f0000);
		frame(ctl(spiee_pkg::OP_WRITE, 1'b1, 3'h2, 1'b0), d);
		wait (busy === 1'b0);
		$display("test page done");
	endtask
	task automatic t_read();
		logic [31:0] d;
		logic [1:0] r;
		set_aw(16'h07fe, 32'h0);
		wr(spiee_pkg::REG_CTRL, ctl(spiee_pkg::OP_READ, 1'b1, 3'h4, 1'b0)
			| 32'h10000, r);
		// Pause lands inside the data bytes
		repeat (600) @(posedge clk);
		wr(spiee_pkg::REG_CTRL, ctl(spiee_pkg::OP_READ, 1'b1, 3'h4, 1'b1), r);
		repeat (100) @(posedge clk);
		wr(spiee_pkg::REG_CTRL, ctl(spiee_pkg::OP_READ, 1'b1, 3'h4, 1'b0), r);
		idle();
		rd(spiee_pkg::REG_RDATA, d);
		chk(d, 32'ha1b25e6f);
		set_aw(16'h07f0, 32'h0);
		frame(ctl(spiee_pkg::OP_READ, 1'b1, 3'h2, 1'b0), d);
		chk({16'h0, d[15:0]}, 32'h0000c3d4);
		// Status write runs the timed cycle, then protects every block
		frame(ctl(spiee_pkg::LATCH_SET_CMD, 1'b0, 3'h0, 1'b0), d);
		set_aw(16'h0000, 32'h0c000000);
		frame(ctl(spiee_pkg::STATUS_WRITE_CMD, 1'b0, 3'h1, 1'b0), d);
		wait (busy === 1'b0);
		frame(ctl(spiee_pkg::STATUS_READ_CMD, 1'b0, 3'h1, 1'b0), d);
		chk({24'h0, d[7:0]}, 32'h0000000c);
		$display("test read done");
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_latch();
		t_page();
		t_read();
		final_report();
	end
endmodule
